// *** hdl/tig_cfg.svh ***
`ifndef TIG_CFG_SVH
`define TIG_CFG_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define TIG_ADDR_INTERP   8'h0c
`define TIG_ADDR_OUTSEL   8'h0e
`define TIG_ADDR_MIRP     8'h10
`define TIG_ADDR_MIRS     8'h11
`define TIG_ADDR_OFFS     8'h12
`define TIG_ADDR_TXGAIN   8'h0a
`define TIG_ADDR_ROUTE    8'h0b

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define TIG_INTERP_HI     7
`define TIG_INTERP_LO     6
`define TIG_MIR_EN_BIT    7
`define TIG_GAIN_UPD_BIT  6
`define TIG_ROUTE_TX_BIT  6
`define TIG_ROUTE_RX_BIT  5
`define TIG_RST_INTERP    8'h00
`define TIG_RST_OUTSEL    8'h00
`define TIG_RST_MIRP      8'h44
`define TIG_RST_MIRS      8'h00
`define TIG_RST_OFFS      8'h00
`define TIG_RST_TXGAIN    8'h00
`define TIG_RST_ROUTE     8'h00
`define TIG_DEF_N         3'h4
`define TIG_DEF_G1        3'h4
`define TIG_DEF_G2        3'h4
`define TIG_DEF_G3        3'h3
`define TIG_DAC_STEPS     6'h0f
`define TIG_AMP_STEP      6'h0c

// ---------------------------------------------------------------------------
// Timing counts (in input-word cycles; 2x latency in half cycles)
// ---------------------------------------------------------------------------
`define TIG_LAT2X_HALF    43
`define TIG_LAT4X         24
`define TIG_PD_DELAY_DEF  8'h60

`endif

// *** hdl/tig_halfband.sv ***
`timescale 1ns/1ps
`default_nettype none
// Half-band interpolate-by-two stage with odd tap count.
module tig_halfband #(
  parameter int TAPS = 11
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_en,
  input  wire logic               i_phase,
  input  wire logic signed [9:0]  i_sample,
  output logic signed [9:0]       o_sample
);
  localparam int HALF = (TAPS + 1) / 4;
  localparam int CTR  = (TAPS - 1) / 4;

  logic signed [9:0]  hist_q [0:2*HALF-1];
  logic signed [17:0] acc;

  // ---------------------------------------------------------------------------
  // Delay line
  // ---------------------------------------------------------------------------
  // Loaded only on the even phase so each input word enters once.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 2*HALF; k++) hist_q[k] <= '0;
    end else if (i_en && !i_phase) begin
      hist_q[0] <= i_sample;
      for (int k = 1; k < 2*HALF; k++) hist_q[k] <= hist_q[k-1];
    end
  end

  // Symmetric odd-phase sum; coefficients are equal weights, a trade of
  // stopband depth for area kept until real coefficients are fixed.
  always_comb begin
    acc = '0;
    for (int k = 0; k < HALF; k++) begin
      acc = acc + 18'(hist_q[k]) + 18'(hist_q[2*HALF-1-k]);
    end
  end

  // Even phase outputs the centre tap, odd phase the interpolated point.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sample <= '0;
    end else if (i_en) begin
      if (!i_phase) o_sample <= hist_q[CTR % (2*HALF)];
      else          o_sample <= 10'(acc / (2*HALF));
    end
  end
endmodule
`default_nettype wire

// *** hdl/tig_pkg.sv ***
package tig_pkg;
  typedef enum logic [1:0] {
    TIG_X4     = 2'b00,
    TIG_X2     = 2'b01,
    TIG_BYPASS = 2'b10,
    TIG_RSVD   = 2'b11
  } tig_interp_t;

  typedef enum logic [2:0] {
    TIG_ST_IDLE  = 3'b001,
    TIG_ST_RUN   = 3'b010,
    TIG_ST_DRAIN = 3'b100
  } tig_pd_state_t;
endpackage

// *** hdl/tig_tx_path.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tig_cfg.svh"

// What this block does
// - Interpolation field 00=4x, 01=2x, 10=bypass (half-duplex only, else zero), 11 reserved.
// - Input rate at most 80 MSPS, update rate at most 200 MSPS.
// - Two cascaded half-band stages, 43 taps then 11 taps.
// - Latency 21.5 input cycles in 2x, 24 in 4x.
// - Half-duplex power-down waits a delay covering filter latency.
// - Direct pins always driven; bit 0 clear enables amplifier path.
// - Primary mirror gain 0..4 in bits 2:0, default 4.
// - Mirror gain fields take effect only while bit 7 set.
// - Secondary mirror gain 0..36 over two registers, default 12.
// - Three secondary stage-gain fields with their step sizes.
// - Offset register holds two 3-bit standing-current codes.
// - Attenuation loaded from gain port or serial, 0.5 dB steps.
// - Attenuation split: converter 7.5 dB, amplifier 6 dB steps.
// - Gain word six bits; converter-only uses its four low bits.
// - Routing select bit 6 steers gain port to transmit; receive bit is not used.
module tig_tx_path
  import tig_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_word_en,
  input  wire logic [9:0]  i_tx_word,
  input  wire logic        i_tx_enable,
  input  wire logic        i_half_duplex,
  input  wire logic [7:0]  i_pd_delay,
  input  wire logic [5:0]  i_parallel_gain_port,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  output logic [9:0]       o_transmit_converter,
  output logic             o_converter_on,
  output logic             o_current_amplifier_on,
  output logic [2:0]       o_primary_gain,
  output logic [2:0]       o_sec_stage1_gain,
  output logic [2:0]       o_sec_stage2_gain,
  output logic [2:0]       o_sec_stage3_gain,
  output logic [2:0]       o_primary_offset_current,
  output logic [2:0]       o_secondary_offset_current,
  output logic [3:0]       o_converter_atten,
  output logic [1:0]       o_amplifier_atten,
  output logic [5:0]       o_tx_gain
);
  logic [7:0]  interp_q, outsel_q, mirp_q, mirs_q, offs_q, txgain_q, route_q;
  logic [1:0]  phase_q;
  logic [7:0]  pd_cnt_q;
  tig_pd_state_t pd_state_q;
  logic signed [9:0] s1_out, s2_out, s2_in;
  tig_interp_t mode;
  logic [5:0]  gain_word;
  logic [5:0]  split_w;

  assign mode = tig_interp_t'(interp_q[`TIG_INTERP_HI:`TIG_INTERP_LO]);

  // Split a 0.5 dB attenuation code: 6 dB amplifier steps only while the rest exceeds 15 converter steps.
  function automatic logic [5:0] tig_split(input logic [5:0] code);
    logic [1:0] coarse;
    logic [5:0] rem;
    coarse = 2'h0;
    rem = code;
    if (rem > `TIG_DAC_STEPS) begin
      coarse = 2'h1;
      rem = rem - `TIG_AMP_STEP;
    end
    if (rem > `TIG_DAC_STEPS) begin
      coarse = 2'h2;
      rem = rem - `TIG_AMP_STEP;
    end
    if (rem > `TIG_DAC_STEPS) begin
      rem = `TIG_DAC_STEPS;
    end
    return {coarse, rem[3:0]};
  endfunction

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  // Reserved and not-used bits are stored but never steer logic.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      interp_q <= `TIG_RST_INTERP;
      outsel_q <= `TIG_RST_OUTSEL;
      mirp_q   <= `TIG_RST_MIRP;
      mirs_q   <= `TIG_RST_MIRS;
      offs_q   <= `TIG_RST_OFFS;
      route_q  <= `TIG_RST_ROUTE;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `TIG_ADDR_INTERP: interp_q <= i_reg_wdata;
        `TIG_ADDR_OUTSEL: outsel_q <= i_reg_wdata;
        `TIG_ADDR_MIRP:   mirp_q   <= i_reg_wdata;
        `TIG_ADDR_MIRS:   mirs_q   <= i_reg_wdata;
        `TIG_ADDR_OFFS:   offs_q   <= i_reg_wdata;
        `TIG_ADDR_ROUTE:  route_q  <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Transmit gain word: serial write needs the update-enable bit, the
  // parallel port loads it continuously while the transmit select is on.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      txgain_q <= `TIG_RST_TXGAIN;
    end else if (i_reg_wr && i_reg_addr == `TIG_ADDR_TXGAIN) begin
      if (i_reg_wdata[`TIG_GAIN_UPD_BIT]) txgain_q <= i_reg_wdata;
    end else if (route_q[`TIG_ROUTE_TX_BIT]) begin
      txgain_q[5:0] <= i_parallel_gain_port;
    end
  end

  // Readback; unmapped addresses return zero.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `TIG_ADDR_INTERP: o_reg_rdata <= interp_q;
        `TIG_ADDR_OUTSEL: o_reg_rdata <= outsel_q;
        `TIG_ADDR_MIRP:   o_reg_rdata <= mirp_q;
        `TIG_ADDR_MIRS:   o_reg_rdata <= mirs_q;
        `TIG_ADDR_OFFS:   o_reg_rdata <= offs_q;
        `TIG_ADDR_ROUTE:  o_reg_rdata <= route_q;
        `TIG_ADDR_TXGAIN: o_reg_rdata <= txgain_q[`TIG_GAIN_UPD_BIT] ?
                                         txgain_q : 8'h00;
        default:          o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Interpolation chain
  // ---------------------------------------------------------------------------
  // Phase counter over update clocks; the input word enable marks phase 0.
  // Word rate limits are the system's job; this logic just follows i_word_en.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= 2'h0;
    end else if (i_word_en) begin
      phase_q <= 2'h1;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // In 4x the first stage runs at half the update rate, in 2x at full rate.
  logic s1_en, s1_ph, s2_ph;
  assign s1_en = (mode == TIG_X4) ? !phase_q[0] : 1'b1;
  assign s1_ph = (mode == TIG_X4) ? phase_q[1] : phase_q[0];
  assign s2_ph = phase_q[0];
  assign s2_in = s1_out;

  tig_halfband #(.TAPS(43)) u_stage1 (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_en     (s1_en),
    .i_phase  (s1_ph),
    .i_sample (signed'(i_tx_word)),
    .o_sample (s1_out)
  );

  tig_halfband #(.TAPS(11)) u_stage2 (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_en     (1'b1),
    .i_phase  (s2_ph),
    .i_sample (s2_in),
    .o_sample (s2_out)
  );

  // Output select per interpolation mode; reserved code outputs zero.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_transmit_converter <= 10'h000;
    end else begin
      case (mode)
        TIG_X4:     o_transmit_converter <= s2_out;
        TIG_X2:     o_transmit_converter <= s1_out;
        TIG_BYPASS: o_transmit_converter <= i_half_duplex ?
                                            i_tx_word : 10'h000;
        default:    o_transmit_converter <= 10'h000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Half-duplex power-down
  // ---------------------------------------------------------------------------
  // Delay counts input words so the last sample clears the filter; the
  // default covers the 24-word 4x latency with margin.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pd_state_q <= TIG_ST_IDLE;
      pd_cnt_q   <= 8'h00;
    end else begin
      case (pd_state_q)
        TIG_ST_IDLE: begin
          if (i_tx_enable || !i_half_duplex) pd_state_q <= TIG_ST_RUN;
        end
        TIG_ST_RUN: begin
          if (i_half_duplex && !i_tx_enable) begin
            pd_state_q <= TIG_ST_DRAIN;
            pd_cnt_q   <= i_pd_delay;
          end
        end
        TIG_ST_DRAIN: begin
          if (i_tx_enable || !i_half_duplex) pd_state_q <= TIG_ST_RUN;
          else if (pd_cnt_q == 8'h00) pd_state_q <= TIG_ST_IDLE;
          else if (i_word_en) pd_cnt_q <= pd_cnt_q - 8'h01;
        end
        default: pd_state_q <= TIG_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Analog controls
  // ---------------------------------------------------------------------------
  // Mirror fields bypassed for defaults while the enable bit is clear.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_converter_on <= 1'b0;
      o_current_amplifier_on <= 1'b0;
      o_primary_gain <= `TIG_DEF_N;
      o_sec_stage1_gain <= `TIG_DEF_G1;
      o_sec_stage2_gain <= `TIG_DEF_G2;
      o_sec_stage3_gain <= `TIG_DEF_G3;
      o_primary_offset_current <= 3'h0;
      o_secondary_offset_current <= 3'h0;
    end else begin
      o_converter_on <= (pd_state_q != TIG_ST_IDLE);
      o_current_amplifier_on <= (pd_state_q != TIG_ST_IDLE) &&
                                !outsel_q[0];
      if (mirp_q[`TIG_MIR_EN_BIT]) begin
        o_primary_gain    <= mirp_q[2:0];
        o_sec_stage1_gain <= mirp_q[6:4];
        o_sec_stage2_gain <= mirs_q[6:4];
        o_sec_stage3_gain <= mirs_q[2:0];
      end else begin
        o_primary_gain    <= `TIG_DEF_N;
        o_sec_stage1_gain <= `TIG_DEF_G1;
        o_sec_stage2_gain <= `TIG_DEF_G2;
        o_sec_stage3_gain <= `TIG_DEF_G3;
      end
      o_primary_offset_current   <= offs_q[2:0];
      o_secondary_offset_current <= offs_q[6:4];
    end
  end

  // Attenuation lookup; the amplifier split assumes mirror defaults.
  assign gain_word = txgain_q[5:0];
  // The split is taken once into a net so both fields come from one lookup.
  assign split_w = tig_split(gain_word);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_converter_atten <= 4'h0;
      o_amplifier_atten <= 2'h0;
      o_tx_gain <= 6'h00;
    end else begin
      o_tx_gain <= gain_word;
      if (outsel_q[0]) begin
        o_converter_atten <= gain_word[3:0];
        o_amplifier_atten <= 2'h0;
      end else begin
        o_converter_atten <= split_w[3:0];
        o_amplifier_atten <= split_w[5:4];
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tig_cfg.svh"
// ------------------------------------
// Transmit path bench
// ------------------------------------
module tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  d;
    logic [7:0]  rb;
    logic [15:0] g;
    logic [15:0] f;
  } tig_row_t;
  logic       i_clk, i_rst, i_reg_wr, i_reg_rd, i_half_duplex, run;
  wire  logic i_word_en, i_tx_enable;
  wire  logic [9:0] i_tx_word;
  logic [7:0] i_reg_addr, i_reg_wdata, i_pd_delay, o_reg_rdata, rb;
  logic [5:0] i_parallel_gain_port, o_tx_gain;
  logic [2:0] ratio, o_primary_gain, o_sec_stage1_gain, o_sec_stage2_gain;
  logic [2:0] o_sec_stage3_gain, o_primary_offset_current;
  logic [2:0] o_secondary_offset_current;
  logic [9:0] o_transmit_converter, prev;
  logic [3:0] o_converter_atten;
  logic [1:0] o_amplifier_atten;
  wire  logic [5:0] atten = {o_amplifier_atten, o_converter_atten};
  logic       o_converter_on, o_current_amplifier_on;
  int         n_fail, num_checks, k;
  // Register writes in order; each row's outputs build on the rows above.
  tig_row_t rows [8] = '{
    '{8'h10, 8'ha3, 8'ha3, 16'h3200, 16'h0000},
    '{8'h11, 8'h52, 8'h52, 16'h3252, 16'h0000},
    '{8'h10, 8'h23, 8'h23, 16'h4443, 16'h0000},
    '{8'h12, 8'h35, 8'h35, 16'h4443, 16'h5300},
    '{8'h0a, 8'h45, 8'h45, 16'h4443, 16'h5305},
    '{8'h0a, 8'h2a, 8'h45, 16'h4443, 16'h5305},
    '{8'h10, 8'h80, 8'h80, 16'h0052, 16'h5305},
    '{8'h10, 8'h44, 8'h44, 16'h4443, 16'h5305}};
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  tig_tx_path dut_u (.i_clk, .i_rst, .i_word_en, .i_tx_word, .i_tx_enable,
    .i_half_duplex, .i_pd_delay, .i_parallel_gain_port, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_transmit_converter,
    .o_converter_on, .o_current_amplifier_on, .o_primary_gain,
    .o_sec_stage1_gain, .o_sec_stage2_gain, .o_sec_stage3_gain,
    .o_primary_offset_current, .o_secondary_offset_current,
    .o_converter_atten, .o_amplifier_atten, .o_tx_gain);
  tig_backend src_u (.i_clk, .i_run(run), .i_ratio(ratio),
    .o_word_en(i_word_en), .o_tx_word(i_tx_word), .o_tx_enable(i_tx_enable));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Inputs always move 1 ns after the edge, never on it.
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rreg(input logic [7:0] a);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    cyc(1);
    i_reg_rd = 1'b0;
    cyc(1);
    rb = o_reg_rdata;
  endtask
  function automatic logic [15:0] gains();
    return {1'b0, o_primary_gain, 1'b0, o_sec_stage1_gain, 1'b0,
      o_sec_stage2_gain, 1'b0, o_sec_stage3_gain};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {i_rst, i_half_duplex, run} = 3'b110;
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = 18'h0;
    i_pd_delay = 8'(`TIG_LAT4X);
    i_parallel_gain_port = 6'h00;
    ratio = 3'h4;
    n_fail = 0;
    num_checks = 0;
    cyc(16);
    i_rst = 1'b0;
    cyc(1);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      chk("gains", gains(), rows[i].g);
      chk("offs_tx", {1'b0, o_primary_offset_current, 1'b0,
        o_secondary_offset_current, 2'b00, o_tx_gain}, rows[i].f);
      rreg(rows[i].a);
      chk("readback", rb, rows[i].rb);
    end
    $display("test register rows done");
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    cyc(1);
    chk("reset_gains", gains(), 16'h4443);
    rreg(`TIG_ADDR_MIRP);
    chk("reset_mirp", rb, 16'h0044);
    rreg(8'h3f);
    chk("unmapped", rb, 16'h0000);
    i_reg_addr = `TIG_ADDR_MIRP;
    i_reg_wdata = 8'h91;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_addr = `TIG_ADDR_MIRS;
    i_reg_wdata = 8'h31;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(1);
    chk("back_to_back", gains(), 16'h1131);
    $display("test reset and back to back done");
    wreg(`TIG_ADDR_ROUTE, 8'h40);
    i_parallel_gain_port = 6'h1b;
    cyc(3);
    chk("port_load", o_tx_gain, 16'h001b);
    wreg(`TIG_ADDR_ROUTE, 8'h00);
    i_parallel_gain_port = 6'h07;
    cyc(3);
    chk("port_off", o_tx_gain, 16'h001b);
    $display("test gain port done");
    for (int m = 0; m < 3; m++) begin
      wreg(`TIG_ADDR_INTERP, {m[1:0], 6'h00});
      ratio = 3'h4 >> m;
      run = 1'b1;
      cyc(60);
      chk("stream", o_transmit_converter != 10'h000, 16'h0001);
      chk("amp_on", o_current_amplifier_on, 16'h0001);
      prev = o_transmit_converter;
      cyc(1);
      prev = o_transmit_converter - prev;
      if (m == 2) chk("step", prev, 16'h0001);
      run = 1'b0;
      cyc(100);
      rreg(`TIG_ADDR_INTERP);
      chk("interp", rb, {8'h00, m[1:0], 6'h00});
    end
    wreg(`TIG_ADDR_INTERP, 8'h00);
    ratio = 3'h4;
    run = 1'b1;
    cyc(40);
    run = 1'b0;
    cyc(3);
    chk("drain_on", o_converter_on, 16'h0001);
    k = 0;
    while (o_converter_on !== 1'b0 && k < 300) begin
      cyc(1);
      k++;
    end
    chk("drain_end", k < 300 && k >= 4 * `TIG_LAT4X - 2, 16'h0001);
    wreg(`TIG_ADDR_OUTSEL, 8'h01);
    run = 1'b1;
    cyc(40);
    chk("amp_off", o_current_amplifier_on, 16'h0000);
    chk("conv_on", o_converter_on, 16'h0001);
    wreg(`TIG_ADDR_TXGAIN, 8'h6b);
    chk("dac_only", atten, 16'h000b);
    wreg(`TIG_ADDR_OUTSEL, 8'h00);
    wreg(`TIG_ADDR_TXGAIN, 8'h67);
    chk("split_max", atten, 16'h002f);
    wreg(`TIG_ADDR_TXGAIN, 8'h54);
    chk("split_mid", atten, 16'h0018);
    i_half_duplex = 1'b0;
    run = 1'b0;
    cyc(120);
    chk("full_duplex", o_converter_on, 16'h0001);
    $display("test stream and power down done");
    close_out();
  end
endmodule
`default_nettype wire

// *** test/tig_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tig_cfg.svh"
// ------------------------------------
// Register to control checks
// ------------------------------------
module tig_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [5:0] i_parallel_gain_port,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [2:0] o_primary_gain,
  input wire logic [2:0] o_sec_stage1_gain,
  input wire logic [2:0] o_sec_stage2_gain,
  input wire logic [2:0] o_sec_stage3_gain,
  input wire logic [2:0] o_primary_offset_current,
  input wire logic [2:0] o_secondary_offset_current,
  input wire logic [5:0] o_tx_gain
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;
  // Write data delayed two edges lines up with the registered controls.
  always_ff @(posedge i_clk) begin
    wd1_q <= i_reg_wdata;
    wd2_q <= wd1_q;
  end
  wire logic wr_mp = i_reg_wr && i_reg_addr == `TIG_ADDR_MIRP;
  wire logic wr_ms = i_reg_wr && i_reg_addr == `TIG_ADDR_MIRS;
  wire logic wr_of = i_reg_wr && i_reg_addr == `TIG_ADDR_OFFS;
  wire logic wr_tx = i_reg_wr && i_reg_addr == `TIG_ADDR_TXGAIN;
  wire logic mapped = i_reg_addr inside {`TIG_ADDR_INTERP, `TIG_ADDR_OUTSEL,
    `TIG_ADDR_MIRP, `TIG_ADDR_MIRS, `TIG_ADDR_OFFS, `TIG_ADDR_TXGAIN,
    `TIG_ADDR_ROUTE};
  rd_unmapped_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 0)
    else $error("unmapped read gave data");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  mir_apply_a: assert property (wr_mp && i_reg_wdata[7] ##1 !wr_mp
    |=> o_primary_gain == wd2_q[2:0] && o_sec_stage1_gain == wd2_q[6:4])
    else $error("mirror gain not applied");
  mir_default_a: assert property (wr_mp && !i_reg_wdata[7] ##1 !wr_mp
    |=> o_primary_gain == `TIG_DEF_N && o_sec_stage1_gain == `TIG_DEF_G1 &&
    o_sec_stage2_gain == `TIG_DEF_G2 && o_sec_stage3_gain == `TIG_DEF_G3)
    else $error("default gains not kept");
  sec_apply_a: assert property (wr_mp && i_reg_wdata[7] ##1 wr_ms
    ##1 !i_reg_wr |=> o_sec_stage2_gain == wd2_q[6:4] &&
    o_sec_stage3_gain == wd2_q[2:0]) else $error("stage gains not applied");
  offs_apply_a: assert property (wr_of ##1 !wr_of
    |=> o_primary_offset_current == wd2_q[2:0] &&
    o_secondary_offset_current == wd2_q[6:4]) else $error("offset wrong");
  tx_load_a: assert property (wr_tx && i_reg_wdata[6] ##1 !wr_tx
    |=> o_tx_gain == wd2_q[5:0] || o_tx_gain == $past(i_parallel_gain_port))
    else $error("tx gain not loaded");
  gain_range_a: assert property (o_primary_gain <= 3'h4 &&
    o_sec_stage1_gain <= 3'h4 && o_sec_stage3_gain <= 3'h5)
    else $error("gain out of range");
  cover property (wr_mp ##2 o_primary_gain == 3'h0);
  cover property (wr_tx && i_reg_wdata[6]);
  cover property (i_reg_rd && !mapped);
endmodule
bind tig_tx_path tig_asserts chk_u (.i_clk, .i_rst, .i_reg_wr, .i_reg_rd,
  .i_reg_addr, .i_reg_wdata, .i_parallel_gain_port, .o_reg_rdata,
  .o_primary_gain, .o_sec_stage1_gain, .o_sec_stage2_gain,
  .o_sec_stage3_gain, .o_primary_offset_current,
  .o_secondary_offset_current, .o_tx_gain);
`default_nettype wire

// *** test/tig_backend.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// Back-end word source
// ------------------------------------
module tig_backend (
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic [2:0] i_ratio,
  output var  logic       o_word_en,
  output var  logic [9:0] o_tx_word,
  output var  logic       o_tx_enable
);
  logic [2:0] cnt_q = 3'h0;
  logic [9:0] nxt_q = 10'h011;
  initial begin
    o_word_en = 1'b0;
    o_tx_word = 10'h155;
    o_tx_enable = 1'b0;
  end
  // One word strobe per i_ratio clocks, bursts or not, as the word clock
  // keeps running; outside bursts the released data lines toggle.
  always @(posedge i_clk) begin
    cnt_q <= (cnt_q + 3'h1 >= i_ratio) ? 3'h0 : cnt_q + 3'h1;
    o_tx_enable <= #1 i_run;
    o_word_en <= #1 cnt_q == 3'h0;
    if (i_run && cnt_q == 3'h0) begin
      o_tx_word <= #1 nxt_q;
      nxt_q <= nxt_q + 10'h001;
    end else if (!i_run) begin
      o_tx_word <= #1 ~o_tx_word;
    end
  end
endmodule
`default_nettype wire
